// ### logic/pfc_seq_map.svh
`ifndef PFC_SEQ_MAP_SVH
`define PFC_SEQ_MAP_SVH
// ****************************************
// Clock and timing
// ****************************************
`define CLK_NS 100
`define CYC_UP(ns) (((ns) + `CLK_NS - 1) / `CLK_NS)
`define BLANK_NS 200
`define BLANK_CYC `CYC_UP(`BLANK_NS)
`define ARM_MIN_NS 200
`define ARM_MIN_CYC `CYC_UP(`ARM_MIN_NS)
`define WDOG_NS 200000
`define WDOG_CYC `CYC_UP(`WDOG_NS)
`define PROBE_NS 2000
`define PROBE_CYC `CYC_UP(`PROBE_NS)
`define L2H_NS 300000
`define L2H_CYC `CYC_UP(`L2H_NS)
`define STRESS_NS 1000000
`define STRESS_CYC `CYC_UP(`STRESS_NS)
`define BO_NS 54000000
`define BO_CYC `CYC_UP(`BO_NS)
`define LOCK_NS 150000000
`define LOCK_CYC `CYC_UP(`LOCK_NS)
`define H2L_NS 25000000
`define H2L_CYC `CYC_UP(`H2L_NS)
// ****************************************
// Register map
// ****************************************
`define CTRL_ADDR 12'h000
`define STATUS_ADDR 12'h004
`define CTRL_EN_BIT 0
`define CTRL_RST 1'b1
`endif

// ### logic/pfc_seq_pkg.sv
package pfc_seq_pkg;
    // Comparator and supervisor flags from the analog side
    typedef struct packed {
        logic ocp;       // Sense above overcurrent threshold
        logic arm;       // Sense above arming threshold
        logic trig;      // Sense below trigger threshold
        logic ton_done;  // Ramp reached on-time demand
        logic bo_start;  // Line above brownout start level
        logic bo_stop;   // Line below brownout stop level
        logic hl;        // Line above high-line level
        logic ll;        // Line below low-line level
        logic vcc_on;    // Supply reached turn-on level
        logic vcc_low;   // Supply below turn-off level
        logic bulk_low;  // Bulk undervoltage
        logic in_reg;    // Amplifier source current <= 0
        logic fb_uv;     // Feedback undervoltage
        logic fault;     // Fault pin fault
        logic fb_open;   // Open feedback pin
        logic tsd;       // Thermal shutdown
        logic line_gone; // Line removal
    } sense_t;
    // Gate sequencer states, one-hot
    typedef enum logic [5:0] {
        G_IDLE = 6'h01,
        G_OFF = 6'h02,
        G_ON = 6'h04,
        G_STRESS = 6'h08,
        G_PROBE = 6'h10,
        G_SHORT = 6'h20
    } gate_st_t;
    // All module state
    typedef struct packed {
        sense_t s1;
        sense_t s2;
        gate_st_t gst;
        logic [20:0] gcnt;
        logic [1:0] arm_cnt;
        logic demag;
        logic gate;
        logic stress;
        logic probe;
        logic short_pin;
        logic bo_ok;
        logic [20:0] bo_cnt;
        logic run;
        logic og;
        logic high_line;
        logic [20:0] l2h_cnt;
        logic [20:0] lock_cnt;
        logic [20:0] h2l_cnt;
        logic sw_en;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_t;
endpackage : pfc_seq_pkg

// ### logic/pfc_sense_and_line_sequencer.sv
`timescale 1ns/1ps
`include "pfc_seq_map.svh"
// Operation
// - Ignore current sense during turn-on blanking
// - After blanking, overcurrent ends gate pulse
// - Demag flag rises above arming threshold
// - Accept arming pulses longer than minimum
// - Trigger crossing after arming starts gate
// - Restart watchdog starts pulse without demag
// - Watchdog expiry probes pin for short
// - Arming during conduction ends pulse, overstress
// - Overstress holds gate off longer timer
// - Faults and start-up clear output good
// - Output good sets on regulation, holds
// - Bulk undervoltage keeps output good low
// - Enable needs brownout start and supply
// - Brownout timer disables if not recovered
// - Line range powers up low-line
// - High-line after level held past delay
// - Low-line entry starts high-line lockout
// - High-to-low timer selects low-line
// - Line select output divides loop gain
// - Shorted pin inhibits until arming seen
// - Feedback undervoltage drops output good
module pfc_sense_and_line_sequencer #(
    parameter int STRESS_CYC = `STRESS_CYC,
    parameter int BO_CYC = `BO_CYC,
    parameter int LOCK_CYC = `LOCK_CYC,
    parameter int H2L_CYC = `H2L_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pfc_seq_pkg::sense_t sense_async,
    output logic gate_drive,
    output logic demag_flag,
    output logic overstress_flag,
    output logic probe_pullup,
    output logic controller_enable,
    output logic output_good,
    output logic high_line_sel
);
    import pfc_seq_pkg::*;

    // ****************************************
    // Timing constants
    // ****************************************
    // Short counts fit the shared counter width
    localparam logic [20:0] BLANK_N = 21'(`BLANK_CYC);
    localparam logic [1:0] ARM_N = 2'(`ARM_MIN_CYC);
    localparam logic [20:0] WDOG_N = 21'(`WDOG_CYC);
    localparam logic [20:0] PROBE_N = 21'(`PROBE_CYC);
    localparam logic [20:0] L2H_N = 21'(`L2H_CYC);
    // Long counts stay parameters for fast sims
    localparam logic [20:0] STRESS_N = 21'(STRESS_CYC);
    localparam logic [20:0] BO_N = 21'(BO_CYC);
    localparam logic [20:0] LOCK_N = 21'(LOCK_CYC);
    localparam logic [20:0] H2L_N = 21'(H2L_CYC);

    // ****************************************
    // State
    // ****************************************
    state_t q;      // Registered state
    state_t d;      // Next state
    sense_t s;      // Synchronised flags
    logic arm_ok;   // Arming pulse long enough
    logic run_n;    // Next enable
    logic og_clr;   // Output good clear term
    logic wr_ctrl;  // Completed write to control
    logic [31:0] status; // Status word

    // Only the second stage is ever read
    assign s = q.s2;
    assign arm_ok = (q.arm_cnt >= ARM_N);
    assign wr_ctrl = psel && penable && q.pready && pwrite
        && (paddr == `CTRL_ADDR);
    assign status = {24'h000000, q.high_line, q.og, q.run,
        q.bo_ok, q.short_pin, q.stress, q.demag, q.gate};

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        d = q;
        // Two-flop synchroniser for all pins
        d.s1 = sense_async;
        d.s2 = q.s1;

        // APB: answer registered in setup cycle
        d.pready = 1'b0;
        if (psel && !penable) begin
            d.pready = 1'b1;
            d.pslverr = 1'b0;
            case (paddr)
                `CTRL_ADDR: begin
                    d.prdata = {31'h00000000, q.sw_en};
                end
                `STATUS_ADDR: begin
                    d.prdata = status;
                end
                default: begin
                    // Unmapped: error, reads zero
                    d.prdata = 32'h00000000;
                    d.pslverr = 1'b1;
                end
            endcase
        end
        // Write lands on the completing edge only
        if (wr_ctrl) begin
            d.sw_en = pwdata[`CTRL_EN_BIT];
        end

        // Brownout supervision
        if (s.bo_stop) begin
            // Timer runs while line below stop level
            if (q.bo_cnt < BO_N) begin
                d.bo_cnt = q.bo_cnt + 21'h000001;
            end
            if (q.bo_cnt >= BO_N - 21'h000001) begin
                d.bo_ok = 1'b0;
            end
        end else begin
            // Recovery resets the timer
            d.bo_cnt = 21'h000000;
            if (s.bo_start && s.vcc_on) begin
                d.bo_ok = 1'b1;
            end
        end

        // Controller enable: any fault stops it
        run_n = d.bo_ok && q.sw_en && !s.vcc_low && !s.tsd
            && !s.fault && !s.fb_open && !s.line_gone
            && !s.fb_uv;
        d.run = run_n;

        // Output good latch: clear beats set
        og_clr = !run_n || s.bulk_low || s.vcc_low || s.fb_uv
            || s.fault || s.fb_open || s.tsd
            || s.line_gone;
        if (og_clr) begin
            d.og = 1'b0;
        end else if (s.in_reg) begin
            d.og = 1'b1;
        end

        // Arming pulse width qualifier
        if (s.arm) begin
            if (!arm_ok) begin
                d.arm_cnt = q.arm_cnt + 2'h1;
            end
        end else begin
            d.arm_cnt = 2'h0;
        end

        // Shared gate timer counts by default
        if (q.gcnt != 21'h1FFFFF) begin
            d.gcnt = q.gcnt + 21'h000001;
        end

        // Gate sequencer
        case (q.gst)
            G_IDLE: begin
                // Start-up: wait for enable
                d.gate = 1'b0;
                d.demag = 1'b0;
                d.gcnt = 21'h000000;
                if (q.run) begin
                    d.gst = G_OFF;
                end
            end
            G_OFF: begin
                // Off time: look for demag
                if (arm_ok) begin
                    d.demag = 1'b1;
                end
                if (q.demag && s.trig) begin
                    // End of demag turns the switch on
                    d.demag = 1'b0;
                    d.gate = 1'b1;
                    d.gcnt = 21'h000000;
                    d.gst = G_ON;
                end else if (q.gcnt >= WDOG_N - 21'h000001) begin
                    // Watchdog: probe pin before pulsing
                    d.probe = 1'b1;
                    d.gcnt = 21'h000000;
                    d.gst = G_PROBE;
                end
            end
            G_PROBE: begin
                // Pull-up on; a healthy pin rises
                if (s.arm) begin
                    d.probe = 1'b0;
                    d.gate = 1'b1;
                    d.gcnt = 21'h000000;
                    d.gst = G_ON;
                end else if (q.gcnt >= PROBE_N - 21'h000001) begin
                    d.short_pin = 1'b1;
                    d.gst = G_SHORT;
                end
            end
            G_SHORT: begin
                // Shorted pin: no pulses until it rises
                if (s.arm) begin
                    d.short_pin = 1'b0;
                    d.probe = 1'b0;
                    d.gate = 1'b1;
                    d.gcnt = 21'h000000;
                    d.gst = G_ON;
                end
            end
            G_ON: begin
                // Both comparators blanked after turn-on
                // Two extra counts cover the sync lag, so pin samples
                // taken inside the blanking time are never acted on
                if (q.gcnt >= BLANK_N + 21'h000002) begin
                    if (s.arm) begin
                        // Inrush or diode short
                        d.gate = 1'b0;
                        d.stress = 1'b1;
                        d.gcnt = 21'h000000;
                        d.gst = G_STRESS;
                    end else if (s.ocp) begin
                        d.gate = 1'b0;
                        d.gcnt = 21'h000000;
                        d.gst = G_OFF;
                    end
                end
                // Normal on-time end from the ramp
                if (s.ton_done && d.gst == G_ON) begin
                    d.gate = 1'b0;
                    d.gcnt = 21'h000000;
                    d.gst = G_OFF;
                end
            end
            G_STRESS: begin
                // Long off time, very low duty ratio
                if (q.gcnt >= STRESS_N - 21'h000001) begin
                    d.stress = 1'b0;
                    d.gcnt = 21'h000000;
                    d.gst = G_OFF;
                end
            end
            default: begin
                // Illegal code: park safely
                d.gate = 1'b0;
                d.gst = G_IDLE;
            end
        endcase
        // Disable overrides every state
        if (!q.run) begin
            d.gate = 1'b0;
            d.demag = 1'b0;
            d.probe = 1'b0;
            d.stress = 1'b0;
            d.gst = G_IDLE;
        end

        // Line range detector
        if (!q.high_line) begin
            // Lockout timer since low-line entry
            if (q.lock_cnt < LOCK_N) begin
                d.lock_cnt = q.lock_cnt + 21'h000001;
            end
            if (s.hl) begin
                if (q.l2h_cnt < L2H_N) begin
                    d.l2h_cnt = q.l2h_cnt + 21'h000001;
                end
            end else begin
                d.l2h_cnt = 21'h000000;
            end
            // Needs both delay and lockout done
            if (q.l2h_cnt >= L2H_N && q.lock_cnt >= LOCK_N) begin
                d.high_line = 1'b1;
                d.h2l_cnt = 21'h000000;
            end
        end else begin
            d.l2h_cnt = 21'h000000;
            if (s.ll) begin
                d.h2l_cnt = q.h2l_cnt + 21'h000001;
            end else begin
                d.h2l_cnt = 21'h000000;
            end
            if (q.h2l_cnt >= H2L_N - 21'h000001 && s.ll) begin
                // Entry to low-line restarts lockout
                d.high_line = 1'b0;
                d.lock_cnt = 21'h000000;
            end
        end
    end

    // ****************************************
    // State register
    // ****************************************
    // Reset values are constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.gst <= G_IDLE;
            q.sw_en <= `CTRL_RST;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // Outputs straight from flops
    // ****************************************
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign gate_drive = q.gate;
    assign demag_flag = q.demag;
    assign overstress_flag = q.stress;
    assign probe_pullup = q.probe;
    assign controller_enable = q.run;
    assign output_good = q.og;
    // High line: ramp three times steeper
    assign high_line_sel = q.high_line;
endmodule : pfc_sense_and_line_sequencer

// ### testbench/pfc_seq_checker.sv
`timescale 1ns/1ps
`include "pfc_seq_map.svh"
// ****************
// Port checker
// ****************
module pfc_seq_checker
    import pfc_seq_pkg::*;
#(
    parameter int STRESS_CYC = 50,
    parameter int BO_CYC = 100,
    parameter int LOCK_CYC = 200,
    parameter int H2L_CYC = 100
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire pfc_seq_pkg::sense_t sense_async,
    input wire logic gate_drive,
    input wire logic demag_flag,
    input wire logic overstress_flag,
    input wire logic probe_pullup,
    input wire logic controller_enable,
    input wire logic output_good,
    input wire logic high_line_sel
);
    localparam int L2H = `L2H_CYC; // Low-to-high dwell in cycles
    int st_q; // Overstress run length
    int hl_q; // High-line level run length
    int ll_q; // Low-line level run length
    int lo_q; // Cycles spent in low-line
    int bs_q; // Brownout level run length
    // Run lengths at the pins; sync delay only makes them longer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= 0;
            hl_q <= 0;
            ll_q <= 0;
            lo_q <= 0;
            bs_q <= 0;
        end else begin
            st_q <= overstress_flag ? st_q + 1 : 0;
            hl_q <= sense_async.hl ? hl_q + 1 : 0;
            ll_q <= sense_async.ll ? ll_q + 1 : 0;
            lo_q <= high_line_sel ? 0 : lo_q + 1;
            bs_q <= sense_async.bo_stop ? bs_q + 1 : 0;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Trigger crossing while armed and the switch is off
    sequence s_demag_end;
        demag_flag && sense_async.trig && !gate_drive && !overstress_flag;
    endsequence
    sequence s_run2;
        controller_enable [*2];
    endsequence
    a_lead_blank: assert property ($rose(gate_drive) ##1 controller_enable
        |-> gate_drive) else $error("gate cut inside blanking");
    a_ocp_cut: assert property ((gate_drive && $past(gate_drive, 2) && sense_async.ocp) [*3]
        |=> !gate_drive) else $error("overcurrent did not end pulse");
    a_demag_qual: assert property ($rose(demag_flag)
        |-> $past(sense_async.arm, 4) && $past(sense_async.arm, 5))
        else $error("demag flag without qualified arming");
    a_trig_gate: assert property (s_demag_end ##1 s_run2 |=> gate_drive)
        else $error("gate late after trigger");
    a_stress_set: assert property ($rose(overstress_flag) |-> $fell(gate_drive))
        else $error("overstress without pulse end");
    a_stress_off: assert property (overstress_flag |-> !gate_drive)
        else $error("gate during overstress");
    a_stress_len: assert property ($fell(overstress_flag) |-> st_q >= STRESS_CYC)
        else $error("overstress off time short");
    a_good_set: assert property ($rose(output_good) |-> $past(sense_async.in_reg, 3))
        else $error("output good without regulation");
    a_good_bulk: assert property (sense_async.bulk_low [*4] |-> !output_good)
        else $error("output good with bulk low");
    a_good_fault: assert property ((sense_async.fb_uv || sense_async.fault
        || sense_async.fb_open || sense_async.tsd || sense_async.line_gone
        || sense_async.vcc_low) [*4] |-> !output_good) else $error("output good in fault");
    a_brown_off: assert property (controller_enable |-> bs_q <= BO_CYC + 4)
        else $error("brownout timer overran");
    a_line_up: assert property ($rose(high_line_sel)
        |-> hl_q >= L2H && lo_q >= LOCK_CYC) else $error("early high-line");
    a_line_down: assert property ($fell(high_line_sel) |-> ll_q >= H2L_CYC)
        else $error("early low-line");
endmodule : pfc_seq_checker
bind pfc_sense_and_line_sequencer pfc_seq_checker #(
    .STRESS_CYC(STRESS_CYC),
    .BO_CYC(BO_CYC),
    .LOCK_CYC(LOCK_CYC),
    .H2L_CYC(H2L_CYC)
) chk_i (.*);

// ### testbench/pfc_stage_model.sv
`timescale 1ns/1ps
// ****************
// Boost stage seen through its comparators
// ****************
module pfc_stage_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic gate_drive,
    input wire logic probe_pullup,
    input wire logic [1:0] mode,
    output logic ocp,
    output logic arm,
    output logic trig,
    output logic ton_done
);
    logic [7:0] on_q; // Cycles since switch on
    logic [7:0] off_q; // Cycles since switch off, saturating
    assign trig = !arm; // Winding rings below trigger level once collapsed
    // Mode 0 normal, 1 overcurrent, 2 overstress, 3 grounded pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_q <= 8'h00;
            off_q <= 8'hFF; // No demag before the first pulse
            ocp <= 1'b0;
            arm <= 1'b0;
            ton_done <= 1'b0;
        end else begin
            on_q <= gate_drive ? on_q + 8'h01 : 8'h00;
            off_q <= gate_drive ? 8'h00 : (off_q == 8'hFF ? off_q : off_q + 8'h01);
            ocp <= gate_drive && mode == 2'h1 && on_q > 8'h03;
            ton_done <= gate_drive && on_q > 8'h08;
            if (mode == 2'h3) begin
                arm <= 1'b0; // Grounded pin never rises, pull-up or not
            end else if (gate_drive) begin
                arm <= mode == 2'h2 && on_q > 8'h03; // Shorted diode
            end else begin
                arm <= off_q < 8'h06 || probe_pullup; // Demag swing or pull-up
            end
        end
    end
endmodule : pfc_stage_model

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`include "pfc_seq_map.svh"
// ****************
// Testbench
// ****************
module tb_top;
    import pfc_seq_pkg::*;
    // Register access: direction, address, data, expected data, expected error
    typedef struct packed {
        logic wr;
        logic [11:0] addr;
        logic [31:0] data;
        logic [31:0] exp;
        logic err;
    } row_t;
    localparam int STRESS = 50; // Shortened overstress off time
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, gate_drive, demag_flag, overstress_flag;
    logic probe_pullup, controller_enable, output_good, high_line_sel;
    logic ocp, arm, trig, ton_done; // From the stage model
    logic [1:0] mode = 2'h0; // Stage behaviour
    sense_t ana = 17'h00100; // Supply up, line below start level
    sense_t sense_async; // Model flags over bench flags
    int error_cnt = 0;
    int checked = 0;
    int n0;
    int n1;
    logic [31:0] rd;
    logic er;
    int flt[6] = '{0, 1, 2, 3, 4, 7}; // Fault flag bit positions
    row_t rows[8] = '{
        '{1'b0, `CTRL_ADDR, 32'h0, 32'h1, 1'b0},
        '{1'b1, `CTRL_ADDR, 32'h0, 32'h0, 1'b0},
        '{1'b0, `CTRL_ADDR, 32'h0, 32'h0, 1'b0},
        '{1'b1, `CTRL_ADDR, 32'h1, 32'h0, 1'b0},
        '{1'b0, `CTRL_ADDR, 32'h0, 32'h1, 1'b0},
        '{1'b1, `STATUS_ADDR, 32'hFF, 32'h0, 1'b0},
        '{1'b0, 12'h008, 32'h0, 32'h0, 1'b1},
        '{1'b1, 12'h008, 32'h1, 32'h0, 1'b1}};
    assign sense_async = {ocp, arm, trig, ton_done, ana[12:0]};
    always #50 pclk = ~pclk;
    pfc_sense_and_line_sequencer #(.STRESS_CYC(STRESS), .BO_CYC(100), .LOCK_CYC(200),
        .H2L_CYC(100)) dut (.*);
    pfc_stage_model stage (.*);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    // Bounded wait for a level, then compare it
    task automatic wait_lvl(ref logic s, input logic v, input int n);
        for (int i = 0; i < n && s !== v; i++) @(posedge pclk);
        chk(s, v);
    endtask : wait_lvl
    // One APB transfer, request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // Length of the next gate pulse
    task automatic pulse(output int len);
        len = 0;
        for (int i = 0; i < 5000 && gate_drive !== 1'b0; i++) @(posedge pclk);
        for (int i = 0; i < 5000 && gate_drive !== 1'b1; i++) @(posedge pclk);
        while (gate_drive === 1'b1 && len < 500) begin
            @(posedge pclk);
            len++;
        end
    endtask : pulse
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude
    // Hang guard, well past the longest expected run
    initial begin
        #(60000 * 100);
        error_cnt++;
        conclude();
    end
    initial begin
        tick(4);
        chk({gate_drive, demag_flag, overstress_flag, probe_pullup, controller_enable,
            output_good, high_line_sel}, 32'h0);
        presetn <= 1'b1;
        tick(30);
        chk(controller_enable, 1'b0);
        ana.bo_start <= 1'b1;
        wait_lvl(controller_enable, 1'b1, 20);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].data);
            chk(er, rows[i].err);
            if (!rows[i].wr) chk(rd, rows[i].exp);
        end
        wait_lvl(probe_pullup, 1'b1, 2100);
        wait_lvl(gate_drive, 1'b1, 40);
        wait_lvl(demag_flag, 1'b1, 60);
        wait_lvl(gate_drive, 1'b1, 10);
        ana.in_reg <= 1'b1;
        wait_lvl(output_good, 1'b1, 10);
        ana.in_reg <= 1'b0;
        tick(10);
        chk(output_good, 1'b1);
        ana.bulk_low <= 1'b1;
        ana.in_reg <= 1'b1;
        wait_lvl(output_good, 1'b0, 6);
        tick(10);
        chk(output_good, 1'b0);
        ana.bulk_low <= 1'b0;
        wait_lvl(output_good, 1'b1, 3000);
        foreach (flt[i]) begin
            ana[flt[i]] <= 1'b1;
            wait_lvl(output_good, 1'b0, 6);
            ana[flt[i]] <= 1'b0;
            wait_lvl(output_good, 1'b1, 3000);
        end
        pulse(n0);
        mode <= 2'h1;
        pulse(n1);
        chk(n1 < n0, 1'b1);
        mode <= 2'h2;
        wait_lvl(overstress_flag, 1'b1, 100);
        chk(gate_drive, 1'b0);
        for (n0 = 0; overstress_flag === 1'b1 && n0 < 500; n0++) @(posedge pclk);
        chk(n0 >= STRESS && n0 <= STRESS + 2, 1'b1);
        mode <= 2'h3;
        wait_lvl(probe_pullup, 1'b1, 2200);
        tick(100);
        chk({probe_pullup, gate_drive}, 2'b10);
        mode <= 2'h0;
        wait_lvl(gate_drive, 1'b1, 20);
        ana.hl <= 1'b1;
        tick(2900);
        chk(high_line_sel, 1'b0);
        wait_lvl(high_line_sel, 1'b1, 200);
        ana.hl <= 1'b0;
        ana.ll <= 1'b1;
        tick(60);
        ana.ll <= 1'b0;
        tick(60);
        chk(high_line_sel, 1'b1);
        ana.ll <= 1'b1;
        wait_lvl(high_line_sel, 1'b0, 120);
        ana.bo_stop <= 1'b1;
        tick(60);
        ana.bo_stop <= 1'b0;
        tick(10);
        chk(controller_enable, 1'b1);
        ana.bo_stop <= 1'b1;
        ana.bo_start <= 1'b0;
        wait_lvl(controller_enable, 1'b0, 120);
        chk(output_good, 1'b0);
        conclude();
    end
endmodule : tb_top
